// File: rtl/ssp_top.sv
// Synchronous serial port: SPI master/slave, I2C slave framing, sleep
`timescale 1ns/1ns
module ssp_top #(
    parameter int HALF_DIV = ssp_pkg::HALF_DIV_DEF
) (
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    // Register port
    input  wire logic [7:0]               addr,
    input  wire logic [7:0]               wr_data,
    input  wire logic                     wr_stb,
    input  wire logic                     rd_stb,
    output logic [7:0]                    rd_data,
    // Power state and interrupt
    input  wire logic                     sleep_req,
    output logic                          irq,
    output logic                          wake,
    // Pins
    input  wire ssp_pkg::ssp_pin_in_type  pins_in,
    output ssp_pkg::ssp_pin_out_type      pins_out
);
    import ssp_pkg::*;

    if (HALF_DIV < 1 || HALF_DIV > 65536)
    begin : g_bad_div
        $error("HALF_DIV must lie between 1 and 65536");
    end

    // =====================================================================
    // Registers and pin synchronisers
    logic [7:0]        con, own_addr, txbuf, rxbuf, irq_st, mask, shreg;
    logic [7:0]        next_irq_st;
    logic [3:0]        bitcnt;
    logic [15:0]       div_cnt;
    logic              bf, rw, seen_start, seen_stop, mst_busy, pend;
    ssp_pin_in_type    s1, s2, s3, flt, next_flt, rise, fall;
    ssp_pin_out_type   po;
    ssp_i2c_state_type st, next_st;
    localparam ssp_pin_in_type PIN_IDLE = '{sck: 1'b0, default: 1'b1}; // SPI clock idles low

    // A change counts only once the second and third stages agree
    assign next_flt = ssp_pin_in_type'((s2 & s3) | (flt & (s2 | s3)));
    assign rise     = ssp_pin_in_type'(next_flt & ~flt);
    assign fall     = ssp_pin_in_type'(~next_flt & flt);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s1  <= PIN_IDLE;
            s2  <= PIN_IDLE;
            s3  <= PIN_IDLE;
            flt <= PIN_IDLE;
        end
        else
        begin
            s1  <= pins_in;
            s2  <= s1;
            s3  <= s2;
            flt <= next_flt;
        end
    end

    // =====================================================================
    // Decode
    wire       en      = con[CON_EN];
    wire       is_mst  = en && con[3:0] == MODE_SPI_MST;
    wire       is_slv  = en && con[3:0] == MODE_SPI_SLV;
    wire       is_i2c  = en && con[3:0] == MODE_I2C_SLV;
    wire       hit_buf = addr == ssp_byte_addr(IDX_BUF);
    wire       wr_buf  = wr_stb && hit_buf;
    wire       rd_buf  = rd_stb && hit_buf;
    wire       wr_irq  = wr_stb && addr == ssp_byte_addr(IDX_IRQ);
    wire       i2c_start = is_i2c && fall.sda && flt.scl;
    wire       i2c_stop  = is_i2c && rise.sda && flt.scl;
    wire       tick    = mst_busy && !sleep_req
                         && div_cnt == 16'(HALF_DIV - 1);
    wire       i2c_sh  = is_i2c && rise.scl
                         && (st == I2C_ADDR || st == I2C_RX || st == I2C_TX);
    wire       shift_in = (is_mst && tick && !po.sck)
                         || (is_slv && !flt.ss_n && rise.sck)
                         || i2c_sh;
    wire       din     = is_mst ? flt.sdi : (is_slv ? next_flt.sdi : next_flt.sda);
    wire [7:0] sh_next = {shreg[6:0], din};
    wire       byte_done = shift_in && bitcnt == LAST_BIT;
    wire       addr_match = sh_next[7:1] == own_addr[6:0];
    wire       busy    = mst_busy || (is_slv && bitcnt != 4'h0) || st == I2C_TX;
    wire       load_cpu = wr_buf && !busy && (is_mst || is_slv);
    wire       wcol    = wr_buf && busy;
    wire       i2c_load = is_i2c && fall.scl && next_st == I2C_TX && st != I2C_TX;
    wire       rx_store = byte_done && (is_mst || is_slv || st == I2C_RX);
    wire [3:0] ev      = {wcol, i2c_stop, i2c_start, rx_store};
    wire       irq_any = |(next_irq_st & mask);

    // Set wins over a write-one clear in the same cycle
    assign next_irq_st = (irq_st & ~(wr_irq ? wr_data : 8'h00)) | {4'h0, ev};

    // =====================================================================
    // Register writes, status and interrupt
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            con      <= REG_RST;
            own_addr <= REG_RST;
            txbuf    <= REG_RST;
            mask     <= REG_RST;
            irq_st   <= REG_RST;
            irq      <= 1'b0;
            wake     <= 1'b0;
        end
        else
        begin
            if (wr_stb && addr == ssp_byte_addr(IDX_CON))
                con <= wr_data;
            if (wr_stb && addr == ssp_byte_addr(IDX_ADDR))
                own_addr <= wr_data;
            if (wr_stb && addr == ssp_byte_addr(IDX_MASK))
                mask <= wr_data;
            if (wr_buf && !busy)
                txbuf <= wr_data;
            irq_st <= next_irq_st;
            irq    <= irq_any;
            wake   <= irq_any && sleep_req;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            bf         <= 1'b0;
            rxbuf      <= REG_RST;
            rw         <= 1'b0;
            seen_start <= 1'b0;
            seen_stop  <= 1'b0;
        end
        else
        begin
            bf <= rx_store || (bf && !rd_buf);
            if (rx_store)
                rxbuf <= sh_next;
            if (byte_done && st == I2C_ADDR)
                rw <= sh_next[0];
            if (i2c_start || i2c_stop)
            begin
                seen_start <= i2c_start;
                seen_stop  <= i2c_stop;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rd_data <= REG_RST;
        else if (!rd_stb)
            rd_data <= REG_RST;
        else if (addr == ssp_byte_addr(IDX_BUF))
            rd_data <= rxbuf;
        else if (addr == ssp_byte_addr(IDX_CON))
            rd_data <= con;
        else if (addr == ssp_byte_addr(IDX_STAT))
            rd_data <= {busy, 2'b00, seen_stop, seen_start, rw, 1'b0, bf};
        else if (addr == ssp_byte_addr(IDX_ADDR))
            rd_data <= own_addr;
        else if (addr == ssp_byte_addr(IDX_IRQ))
            rd_data <= irq_st;
        else if (addr == ssp_byte_addr(IDX_MASK))
            rd_data <= mask;
        else
            rd_data <= REG_RST;
    end

    // =====================================================================
    // Shift register, shared by all modes
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || (is_slv && flt.ss_n) || !en)
        begin
            shreg  <= REG_RST;
            bitcnt <= 4'h0;
        end
        else if (load_cpu || i2c_load || i2c_start)
        begin
            shreg  <= i2c_start ? REG_RST : (load_cpu ? wr_data : txbuf);
            bitcnt <= 4'h0;
        end
        else if (shift_in)
        begin
            shreg  <= sh_next;
            bitcnt <= byte_done ? 4'h0 : bitcnt + 4'h1;
        end
    end

    // =====================================================================
    // SPI master clock; while asleep nothing advances
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || !is_mst)
        begin
            mst_busy <= 1'b0;
            div_cnt  <= 16'h0000;
        end
        else if (load_cpu)
        begin
            mst_busy <= 1'b1;
            div_cnt  <= 16'h0000;
        end
        else if (tick)
        begin
            div_cnt  <= 16'h0000;
            mst_busy <= !(po.sck && bitcnt == 4'h0);
        end
        else if (mst_busy && !sleep_req)
            div_cnt <= div_cnt + 16'h0001;
    end

    // =====================================================================
    // I2C slave framing
    always_comb
    begin
        next_st = st;
        if (!is_i2c || i2c_stop)
            next_st = I2C_IDLE;
        else if (i2c_start)
            next_st = I2C_ADDR;
        else
            case (st)
                I2C_ADDR:
                    if (byte_done && !addr_match)
                        next_st = I2C_IDLE;
                    else if (fall.scl && pend)
                        next_st = I2C_ACK_A;
                I2C_ACK_A:
                    if (fall.scl)
                        next_st = rw ? I2C_TX : I2C_RX;
                I2C_RX:
                    if (fall.scl && pend)
                        next_st = I2C_ACK_R;
                I2C_ACK_R:
                    if (fall.scl)
                        next_st = I2C_RX;
                I2C_TX:
                    if (fall.scl && pend)
                        next_st = I2C_WAIT_M;
                I2C_WAIT_M:
                    if (rise.scl && next_flt.sda)
                        next_st = I2C_IDLE;
                    else if (fall.scl)
                        next_st = I2C_TX;
                default:
                    next_st = I2C_IDLE;
            endcase
    end

    wire tx_bit   = (st == I2C_TX) ? shreg[7] : txbuf[7];
    wire ack_next = next_st == I2C_ACK_A || next_st == I2C_ACK_R;
    // Pull low for zero, release for one; only moved while clock is low
    wire sda_next = ack_next || (next_st == I2C_TX && !tx_bit);

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            st   <= I2C_IDLE;
            pend <= 1'b0;
        end
        else
        begin
            st   <= next_st;
            pend <= (byte_done && is_i2c) || (pend && !fall.scl && !i2c_start);
        end
    end

    // =====================================================================
    // Pin outputs
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            po <= '0;
        else
        begin
            po.scl_out <= 1'b0;
            po.sda_out <= 1'b0;
            po.scl_oe  <= 1'b0;
            po.sdo_oe  <= is_mst || (is_slv && !flt.ss_n);
            if (!is_i2c)
                po.sda_oe <= 1'b0;
            else if (fall.scl || next_st == I2C_IDLE)
                po.sda_oe <= sda_next && next_st != I2C_IDLE;
            if (!is_mst)
                po.sck <= 1'b0;
            else if (tick)
                po.sck <= !po.sck;
            if (load_cpu)
                po.sdo <= wr_data[7];
            else if ((is_mst && tick && po.sck) || (is_slv && fall.sck))
                po.sdo <= shreg[7];
        end
    end

    assign pins_out = po;

    // =====================================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    freeze_hold_a: assert property (is_mst && sleep_req && $past(sleep_req) && !load_cpu
        |=> $stable(po.sck) && $stable(bitcnt)) else $error("master moved while asleep");
    resume_a: assert property (tick && is_mst |=> po.sck != $past(po.sck))
        else $error("master clock did not toggle");
    slave_sleep_a: assert property (is_slv && sleep_req && shift_in
        |=> shreg == $past(sh_next)) else $error("slave stopped in sleep");
    byte_flag_a: assert property (is_slv && byte_done && !(is_slv && flt.ss_n)
        |=> irq_st[IRQ_DONE] ##1 (irq == mask[IRQ_DONE] || $past(wr_irq)))
        else $error("byte flag missing");
    wake_a: assert property (sleep_req && irq_any |=> wake)
        else $error("no wake");
    od_level_a: assert property (!po.sda_out && !po.scl_out && !po.scl_oe)
        else $error("open drain drove high");
    addr_ack_a: assert property (st == I2C_ADDR && fall.scl && pend && !i2c_stop
        && !i2c_start |=> st == I2C_ACK_A && po.sda_oe) else $error("address not acked");
    role_a: assert property (st == I2C_ACK_A && fall.scl && is_i2c && !i2c_stop
        |=> st == ($past(rw) ? I2C_TX : I2C_RX)) else $error("wrong role");
    start_det_a: assert property (i2c_start && !i2c_stop |=> st == I2C_ADDR)
        else $error("start missed");
    stop_det_a: assert property (i2c_stop |=> st == I2C_IDLE && !po.sda_oe)
        else $error("stop missed");
    msb_first_a: assert property (load_cpu |=> po.sdo == $past(wr_data[7]))
        else $error("not msb first");
    ack_hold_a: assert property (st == I2C_ACK_R && is_i2c |-> po.sda_oe)
        else $error("ack not low");
    low_change_a: assert property ($changed(po.sda_oe) && st != I2C_IDLE && is_i2c
        |-> !flt.scl) else $error("data moved with clock high");

    mst_done_c: cover property (mst_busy ##1 !mst_busy);
    slv_sleep_c: cover property (is_slv && sleep_req && byte_done);
    i2c_read_c: cover property (st == I2C_ACK_A && rw ##[1:200] st == I2C_TX);
endmodule : ssp_top

// File: inc/ssp_pkg.sv
// Constants, types and register map of the synchronous serial port
package ssp_pkg;
    // =====================================================================
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_BUF  = 8'h00;
    localparam logic [7:0] IDX_CON  = 8'h01;
    localparam logic [7:0] IDX_STAT = 8'h02;
    localparam logic [7:0] IDX_ADDR = 8'h03;
    localparam logic [7:0] IDX_IRQ  = 8'h04;
    localparam logic [7:0] IDX_MASK = 8'h05;
    // =====================================================================
    // Fields
    localparam int CON_EN     = 5;
    localparam int STAT_BF    = 0;
    localparam int STAT_RW    = 2;
    localparam int STAT_START = 3;
    localparam int STAT_STOP  = 4;
    localparam int STAT_BUSY  = 7;
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_START  = 1;
    localparam int IRQ_STOP   = 2;
    localparam int IRQ_WCOL   = 3;
    localparam logic [3:0] MODE_SPI_MST = 4'h0;
    localparam logic [3:0] MODE_SPI_SLV = 4'h4;
    localparam logic [3:0] MODE_I2C_SLV = 4'h6;
    localparam logic [7:0] REG_RST      = 8'h00;
    localparam logic [3:0] LAST_BIT     = 4'h7;
    localparam int         HALF_DIV_DEF = 4;
    // =====================================================================
    // Types
    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
        logic scl;
        logic sda;
    } ssp_pin_in_type;
    typedef struct packed {
        logic sck;
        logic sdo;
        logic sdo_oe;
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } ssp_pin_out_type;
    typedef enum logic [2:0] {
        I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_RX, I2C_ACK_R, I2C_TX, I2C_WAIT_M
    } ssp_i2c_state_type;
    function automatic logic [7:0] ssp_byte_addr(input logic [7:0] idx);
        ssp_byte_addr = {idx[5:0], 2'b00};
    endfunction : ssp_byte_addr
endpackage : ssp_pkg

// File: bench/ssp_far_end.sv
// Far-side model: SPI slave and master, I2C master on pulled-up lines
`timescale 1ns/1ns
module ssp_far_end (
    // Pins seen from outside the port
    input  wire ssp_pkg::ssp_pin_out_type pins_out,
    output ssp_pkg::ssp_pin_in_type       pins_in
);
    import ssp_pkg::*;
    logic       sck_m    = 1'b0;
    logic       sdi_v    = 1'b1;
    logic       ss_n_v   = 1'b1;
    logic       scl_pull = 1'b0;
    logic       sda_pull = 1'b0;
    logic [7:0] spi_rx   = 8'h00;
    logic [7:0] spi_tx   = 8'h00;
    // ================================================================
    // Open-drain wires: anyone pulling wins, else the pull-up
    wire        scl      = ~(scl_pull | pins_out.scl_oe);
    wire        sda      = ~(sda_pull | pins_out.sda_oe);
    assign pins_in = {sck_m, sdi_v, ss_n_v, scl, sda};
    // ================================================================
    // SPI slave facing the device as master, MSB first
    always @(posedge pins_out.sck) spi_rx <= {spi_rx[6:0], pins_out.sdo};
    always @(negedge pins_out.sck)
    begin
        spi_tx = spi_tx << 1;
        sdi_v  = spi_tx[7];
    end
    task automatic spi_load(input logic [7:0] b);
        spi_tx = b;
        sdi_v  = b[7];
    endtask : spi_load
    // SPI master at 160 ns per bit; odd start offset keeps phase unrelated
    task automatic spi_send(input logic [7:0] b);
        #7 ss_n_v = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            sdi_v = b[i];
            #80 sck_m = 1'b1;
            #80 sck_m = 1'b0;
        end
        #80 ss_n_v = 1'b1;
        // Released line must not keep showing the last bit
        sdi_v = ~sdi_v;
    endtask : spi_send
    // ================================================================
    // I2C master; low phase is long so a late slave release still settles
    task automatic i2c_start();
        #160 sda_pull = 1'b1;
        #160 scl_pull = 1'b1;
    endtask : i2c_start
    task automatic i2c_stop();
        #80 sda_pull = 1'b1;
        #80 scl_pull = 1'b0;
        #160 sda_pull = 1'b0;
        #160;
    endtask : i2c_stop
    task automatic i2c_byte(input logic [7:0] b, input logic ak, output logic [7:0] g,
                            output logic ka);
        for (int i = 8; i >= 0; i--)
        begin
            #80 sda_pull = (i == 0) ? ~ak : ~b[i-1];
            #80 scl_pull = 1'b0;
            #80 if (i > 0) g[i-1] = sda;
            else ka = sda;
            #80 scl_pull = 1'b1;
        end
    endtask : i2c_byte
endmodule : ssp_far_end

// File: bench/ssp_top_bench.sv
// Self-checking bench: registers, SPI both roles, sleep, I2C slave
`timescale 1ns/1ns
module ssp_top_bench;
    import ssp_pkg::*;
    localparam int   HALF        = 8;
    logic            clk_sys     = 1'b0;
    logic            sys_rst     = 1'b1;
    logic [7:0]      addr        = 8'h00;
    logic [7:0]      wr_data     = 8'h00;
    logic            wr_stb      = 1'b0;
    logic            rd_stb      = 1'b0;
    logic            sleep_req   = 1'b0;
    logic [7:0]      rd_data;
    logic            irq;
    logic            wake;
    ssp_pin_in_type  pins_in;
    ssp_pin_out_type pins_out;
    int              n_errors    = 0;
    int              checks_done = 0;
    int              cycles      = 0;
    int              flips;
    integer          seed        = 32'h956b_5f03;
    logic [7:0]      r, a, b, t;
    logic            k;
    logic [7:0]      exp_q[$];
    ssp_top #(.HALF_DIV(HALF)) ssp_top_i (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .sleep_req(sleep_req),
        .irq(irq), .wake(wake), .pins_in(pins_in), .pins_out(pins_out));
    ssp_far_end ssp_far_end_i (.pins_out(pins_out), .pins_in(pins_in));
    initial forever #10 clk_sys = ~clk_sys;
    // ================================================================
    // Shared tasks
    task automatic give_verdict();
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_sys);
        addr    <= {idx[5:0], 2'b00};
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk_sys);
        wr_stb  <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        @(posedge clk_sys);
        addr   <= {idx[5:0], 2'b00};
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk_sys);
    endtask : wait_irq
    // Hang guard, far above the fewer than two thousand cycles the run needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    // ================================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            rd((i == 6) ? 8'h3F : i[7:0], r);
            chk("reset_reg", REG_RST, r);
        end
        // SPI master with a refused write and a sleep in mid-byte
        b = 8'($random(seed));
        t = 8'($random(seed));
        ssp_far_end_i.spi_load(t);
        wr(IDX_CON, {4'h2, MODE_SPI_MST});
        wr(IDX_MASK, 8'h01);
        wr(IDX_BUF, b);
        wr(IDX_BUF, ~b);
        repeat (3 * HALF) @(posedge clk_sys);
        sleep_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        k = pins_out.sck;
        flips = 0;
        repeat (40)
        begin
            @(negedge clk_sys);
            if (pins_out.sck !== k) flips++;
        end
        chk("sck_frozen", 8'h00, flips[7:0]);
        rd(IDX_STAT, r);
        chk("busy_held", 8'h01, {7'h00, r[STAT_BUSY]});
        @(posedge clk_sys);
        sleep_req <= 1'b0;
        wait_irq(40 * HALF);
        chk("done_irq", 8'h01, {7'h00, irq});
        rd(IDX_IRQ, r);
        chk("irq_status", 8'h09, r);
        rd(IDX_BUF, r);
        chk("spi_rx", t, r);
        chk("far_rx", b, ssp_far_end_i.spi_rx);
        wr(IDX_IRQ, 8'h09);
        rd(IDX_IRQ, r);
        chk("irq_clear", 8'h00, r);
        // SPI slave while asleep, interrupt enabled then disabled
        wr(IDX_CON, {4'h2, MODE_SPI_SLV});
        for (int m = 1; m >= 0; m--)
        begin
            b = 8'($random(seed));
            exp_q.push_back(b);
            @(posedge clk_sys);
            sleep_req <= 1'b1;
            wr(IDX_MASK, {7'h00, m[0]});
            ssp_far_end_i.spi_send(b);
            repeat (10) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("wake", {7'h00, m[0]}, {7'h00, wake});
            rd(IDX_STAT, r);
            chk("buf_full", 8'h01, {7'h00, r[STAT_BF]});
            rd(IDX_BUF, r);
            chk("slave_rx", exp_q.pop_front(), r);
            wr(IDX_IRQ, 8'h0F);
            sleep_req <= 1'b0;
        end
        // I2C slave: write, foreign address, read
        a = {1'b0, 7'($random(seed))};
        b = 8'($random(seed));
        wr(IDX_CON, {4'h2, MODE_I2C_SLV});
        wr(IDX_ADDR, a);
        wr(IDX_MASK, 8'h07);
        ssp_far_end_i.i2c_start();
        ssp_far_end_i.i2c_byte({a[6:0], 1'b0}, 1'b1, r, k);
        chk("addr_ack", 8'h00, {7'h00, k});
        ssp_far_end_i.i2c_byte(b, 1'b1, r, k);
        chk("data_ack", 8'h00, {7'h00, k});
        ssp_far_end_i.i2c_stop();
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("i2c_irq", 8'h01, {7'h00, irq});
        rd(IDX_STAT, r);
        chk("i2c_stat", 8'h11, r);
        rd(IDX_BUF, r);
        chk("i2c_rx", b, r);
        rd(IDX_IRQ, r);
        chk("i2c_events", 8'h07, r);
        wr(IDX_IRQ, 8'h07);
        ssp_far_end_i.i2c_start();
        ssp_far_end_i.i2c_byte({a[6:0] ^ 7'h01, 1'b0}, 1'b1, r, k);
        chk("foreign_ack", 8'h01, {7'h00, k});
        ssp_far_end_i.i2c_stop();
        t = 8'($random(seed));
        wr(IDX_BUF, t);
        ssp_far_end_i.i2c_start();
        ssp_far_end_i.i2c_byte({a[6:0], 1'b1}, 1'b1, r, k);
        chk("read_ack", 8'h00, {7'h00, k});
        ssp_far_end_i.i2c_byte(8'hFF, 1'b1, r, k);
        chk("i2c_tx", t, r);
        ssp_far_end_i.i2c_stop();
        rd(IDX_STAT, r);
        chk("read_stat", 8'h14, r);
        give_verdict();
    end
endmodule : ssp_top_bench
